// File: logic/pcu_top.sv
// port pin control unit: direction, pulls, drive, clock out, ext irq config
//--------------------------------------------------------------------------
//--------------------------------------------------------------------------
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "pcu_params.svh"
module pcu_top
  import pcu_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       special_mode,
  input  wire logic [7:0] seg_en_a,
  input  wire logic [7:0] seg_en_b,
  input  wire logic [7:0] port_a_in,
  input  wire logic [7:0] port_b_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe,
  output logic      [7:0] port_a_ie,
  output logic      [7:0] port_b_out,
  output logic      [7:0] port_b_oe,
  output logic      [7:0] port_b_ie,
  output logic      [7:0] port_a_pulldown,
  output logic      [7:0] port_b_pulldown,
  output logic      [7:0] port_a_weak,
  output logic      [7:0] port_b_weak,
  input  wire logic       debug_pin_is_output,
  output logic            debug_pullup,
  output logic            bus_clock_out,
  input  wire logic       maskable_pin,
  input  wire logic       nonmaskable_interrupt_pin,
  input  wire logic       irq_service_ack,
  output logic            maskable_irq_req,
  output logic            nonmaskable_irq_req,
  output logic            irq
);

  //------------------------------------------------------------------------
  // registers
  //------------------------------------------------------------------------
  logic [7:0] port_a_data;
  logic [7:0] port_b_data;
  logic [7:0] port_a_direction;
  logic [7:0] port_b_direction;
  logic [7:0] pull_control;
  logic [7:0] drive_strength_select;
  logic [7:0] clock_output_control;
  logic [7:0] ext_interrupt_config;
  logic       irq_cfg_locked;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [7:0] pin_a_sync;
  logic [7:0] pin_b_sync;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [7:0] port_read(input logic [7:0] dir,
                                           input logic [7:0] data,
                                           input logic [7:0] pin);
    port_read = (dir & data) | (~dir & pin);
  endfunction

  pcu_sync8 u_sync_a
  (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (port_a_in),
    .sync_out (pin_a_sync)
  );

  // the registered enable plus two flops of sync latency bound the read after a direction change
  pcu_sync8 u_sync_b
  (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (port_b_in),
    .sync_out (pin_b_sync)
  );

  wire wr_data_a = reg_wr && hit(reg_addr, `PCU_OFF_PORTA_DATA);
  wire wr_data_b = reg_wr && hit(reg_addr, `PCU_OFF_PORTB_DATA);
  wire wr_dir_a  = reg_wr && hit(reg_addr, `PCU_OFF_PORTA_DIR);
  wire wr_dir_b  = reg_wr && hit(reg_addr, `PCU_OFF_PORTB_DIR);
  wire wr_pull   = reg_wr && hit(reg_addr, `PCU_OFF_PULL);
  wire wr_drive  = reg_wr && hit(reg_addr, `PCU_OFF_DRIVE);
  wire wr_clkout = reg_wr && hit(reg_addr, `PCU_OFF_CLKOUT);
  wire wr_irqcfg = reg_wr && hit(reg_addr, `PCU_OFF_IRQCFG);
  wire wr_iclr   = reg_wr && hit(reg_addr, `PCU_OFF_IRQ_CLEAR);
  wire wr_ien    = reg_wr && hit(reg_addr, `PCU_OFF_IRQ_ENABLE);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      port_a_data <= `PCU_RST_BYTE;
      port_b_data <= `PCU_RST_BYTE;
    end
    else
    begin
      if (wr_data_a)
        port_a_data <= reg_wdata;
      if (wr_data_b)
        port_b_data <= reg_wdata;
    end
  end

  // direction registers take any write in any mode
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      port_a_direction <= `PCU_RST_BYTE;
      port_b_direction <= `PCU_RST_BYTE;
    end
    else
    begin
      if (wr_dir_a)
        port_a_direction <= reg_wdata;
      if (wr_dir_b)
        port_b_direction <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pull_control <= `PCU_RST_BYTE;
    else if (wr_pull)
    begin
      pull_control[`PCU_BIT_B_PULLDN] <= reg_wdata[`PCU_BIT_B_PULLDN];
      pull_control[`PCU_BIT_A_PULLDN] <= reg_wdata[`PCU_BIT_A_PULLDN];
      if (special_mode)
        pull_control[`PCU_BIT_DBG_PULLUP] <= reg_wdata[`PCU_BIT_DBG_PULLUP];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      drive_strength_select <= `PCU_RST_BYTE;
    else if (wr_drive)
      drive_strength_select <= reg_wdata & `PCU_MASK_DRIVE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      clock_output_control <= `PCU_RST_CLKOUT;
    else if (wr_clkout)
      clock_output_control <= reg_wdata & (`PCU_MASK_CLKOUT | 8'h1f);
  end

  // write-once bits: first normal-mode write locks them against normal-mode writes until reset
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ext_interrupt_config <= `PCU_RST_IRQCFG;
      irq_cfg_locked       <= 1'b0;
    end
    else if (wr_irqcfg)
    begin
      ext_interrupt_config[`PCU_BIT_MASK_CONN] <= reg_wdata[`PCU_BIT_MASK_CONN];
      if (special_mode || !irq_cfg_locked)
      begin
        ext_interrupt_config[`PCU_BIT_EDGE_SEL] <= reg_wdata[`PCU_BIT_EDGE_SEL];
        ext_interrupt_config[`PCU_BIT_NMI_CONN] <= reg_wdata[`PCU_BIT_NMI_CONN];
      end
      if (!special_mode)
        irq_cfg_locked <= 1'b1;
    end
  end

  //------------------------------------------------------------------------
  // read port
  //------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `PCU_OFF_PORTA_DATA: reg_rdata <= port_read(port_a_direction, port_a_data, pin_a_sync);
        `PCU_OFF_PORTB_DATA: reg_rdata <= port_read(port_b_direction, port_b_data, pin_b_sync);
        `PCU_OFF_PORTA_DIR:  reg_rdata <= port_a_direction;
        `PCU_OFF_PORTB_DIR:  reg_rdata <= port_b_direction;
        `PCU_OFF_PULL:       reg_rdata <= pull_control & `PCU_MASK_PULL;
        `PCU_OFF_DRIVE:      reg_rdata <= drive_strength_select;
        `PCU_OFF_CLKOUT:     reg_rdata <= clock_output_control;
        `PCU_OFF_IRQCFG:     reg_rdata <= ext_interrupt_config & `PCU_MASK_IRQCFG;
        `PCU_OFF_IRQ_STATUS: reg_rdata <= {6'h00, irq_status};
        `PCU_OFF_IRQ_ENABLE: reg_rdata <= {6'h00, irq_enable};
        default:             reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  //------------------------------------------------------------------------
  // pin control
  //------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      port_a_out <= 8'h00;
      port_a_oe  <= 8'h00;
      port_a_ie  <= 8'h00;
      port_b_out <= 8'h00;
      port_b_oe  <= 8'h00;
      port_b_ie  <= 8'h00;
    end
    else
    begin
      port_a_out <= port_a_data;
      port_a_oe  <= port_a_direction & ~seg_en_a;
      port_a_ie  <= ~port_a_direction & ~seg_en_a;
      port_b_out <= port_b_data;
      port_b_oe  <= port_b_direction & ~seg_en_b;
      port_b_ie  <= ~port_b_direction & ~seg_en_b;
    end
  end

  // pull and drive are per-pin so an output pin never sees a pull
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      port_a_pulldown <= 8'h00;
      port_b_pulldown <= 8'h00;
      port_a_weak     <= 8'h00;
      port_b_weak     <= 8'h00;
      debug_pullup    <= 1'b0;
    end
    else
    begin
      port_a_pulldown <= {8{pull_control[`PCU_BIT_A_PULLDN]}} & ~port_a_direction & ~seg_en_a;
      port_b_pulldown <= {8{pull_control[`PCU_BIT_B_PULLDN]}} & ~port_b_direction & ~seg_en_b;
      port_a_weak     <= {8{drive_strength_select[`PCU_BIT_A_WEAK]}} & port_a_direction;
      port_b_weak     <= {8{drive_strength_select[`PCU_BIT_B_WEAK]}} & port_b_direction;
      debug_pullup    <= pull_control[`PCU_BIT_DBG_PULLUP] & ~debug_pin_is_output;
    end
  end

  //------------------------------------------------------------------------
  // clock output divider
  //------------------------------------------------------------------------
  // divide by 2*(div+1), times 16 with prescale: out toggles once per tick, so duty is always half
  pcu_clk_state_t clk_state;
  logic [4:0]     div_cnt;
  logic [3:0]     pre_cnt;
  logic           pre_tick;
  wire  [4:0]     div_val = clock_output_control[4:0];
  wire            pre_on  = clock_output_control[`PCU_BIT_PRE16];
  wire            clk_dis = clock_output_control[`PCU_BIT_CLK_DIS];

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      clk_state <= PCU_CLK_OFF;
    else
    begin
      case (clk_state)
        PCU_CLK_OFF:   clk_state <= clk_dis ? PCU_CLK_OFF : PCU_CLK_RSYNC;
        PCU_CLK_RUN:   clk_state <= clk_dis ? PCU_CLK_OFF :
                                    (wr_clkout ? PCU_CLK_RSYNC : PCU_CLK_RUN);
        PCU_CLK_RSYNC: clk_state <= clk_dis ? PCU_CLK_OFF : PCU_CLK_RUN;
        default:       clk_state <= PCU_CLK_OFF;
      endcase
    end
  end

  // stage one: tick once per (div+1) bus clocks
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || clk_state != PCU_CLK_RUN)
    begin
      div_cnt  <= `PCU_DIV_ZERO;
      pre_cnt  <= 4'h0;
      pre_tick <= 1'b0;
    end
    else
    begin
      if (div_cnt == div_val)
        div_cnt <= `PCU_DIV_ZERO;
      else
        div_cnt <= div_cnt + 5'h01;
      if (div_cnt == div_val)
        pre_cnt <= pre_cnt + 4'h1;
      pre_tick <= (div_cnt == div_val) && (!pre_on || pre_cnt == `PCU_PRE16_LAST);
    end
  end

  // when undivided the output toggles on every bus clock without using the tick stream
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || clk_state != PCU_CLK_RUN)
      bus_clock_out <= 1'b0;
    else if (!pre_on && div_val == `PCU_DIV_ZERO)
      bus_clock_out <= ~bus_clock_out;
    else if (pre_tick)
      bus_clock_out <= ~bus_clock_out;
  end

  //------------------------------------------------------------------------
  // external interrupt pins
  //------------------------------------------------------------------------
  logic mask_prev;
  logic edge_latch;
  wire  edge_mode = ext_interrupt_config[`PCU_BIT_EDGE_SEL];
  wire  mask_conn = ext_interrupt_config[`PCU_BIT_MASK_CONN];
  wire  nmi_conn  = ext_interrupt_config[`PCU_BIT_NMI_CONN];
  wire  fall_seen = mask_prev & ~maskable_pin & edge_mode;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      mask_prev  <= 1'b1;
      edge_latch <= 1'b0;
    end
    else
    begin
      mask_prev <= maskable_pin;
      if (fall_seen)
        edge_latch <= 1'b1;
      else if (irq_service_ack || !edge_mode)
        edge_latch <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      maskable_irq_req    <= 1'b0;
      nonmaskable_irq_req <= 1'b0;
    end
    else
    begin
      maskable_irq_req    <= mask_conn & (edge_mode ? (edge_latch | fall_seen) : ~maskable_pin);
      nonmaskable_irq_req <= nmi_conn & ~nonmaskable_interrupt_pin;
    end
  end

  // sticky status: bit0 maskable request, bit1 nonmaskable; set beats clear
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      irq_status <= 2'h0;
      irq_enable <= 2'h0;
    end
    else
    begin
      irq_status <= (irq_status & ~(wr_iclr ? reg_wdata[1:0] : 2'h0))
                    | {nonmaskable_irq_req, maskable_irq_req};
      if (wr_ien)
        irq_enable <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_enable);
  end

  //------------------------------------------------------------------------
  // checks
  //------------------------------------------------------------------------
  dir_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rstn) |-> port_b_oe == ($past(port_b_direction) & ~$past(seg_en_b)))
    else $error("port b output enable wrong");
  seg_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rstn) |-> ((port_b_oe | port_b_ie) & $past(seg_en_b)) == 8'h00)
    else $error("segment pin not disabled");
  rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_rd && reg_addr == `PCU_OFF_RSVD_A |=> reg_rdata == 8'h00)
    else $error("reserved read nonzero");
  dbg_lock_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_pull && !special_mode |=> $stable(pull_control[`PCU_BIT_DBG_PULLUP]))
    else $error("debug pullup written in normal mode");
  pull_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 (port_b_pulldown & $past(port_b_direction)) == 8'h00)
    else $error("pulldown on output pin");
  once_lock_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_irqcfg && irq_cfg_locked && !special_mode
    |=> $stable(ext_interrupt_config[`PCU_BIT_EDGE_SEL]))
    else $error("write once bit changed");
  clk_stop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_dis [*3] |-> !bus_clock_out)
    else $error("clock out running while disabled");
  edge_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    edge_latch && edge_mode && !irq_service_ack && !wr_irqcfg |=> edge_latch)
    else $error("edge latch lost");
  nmi_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !$past(nmi_conn) |-> !nonmaskable_irq_req)
    else $error("nmi request while disconnected");
  read_src_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_rd && reg_addr == `PCU_OFF_PORTB_DATA && port_b_direction == 8'hff
    |=> reg_rdata == $past(port_b_data))
    else $error("port read source wrong");

  cov_edge_c:  cover property (@(posedge sys_clk) fall_seen && mask_conn);
  cov_lock_c:  cover property (@(posedge sys_clk) wr_irqcfg && irq_cfg_locked);
  cov_div_c:   cover property (@(posedge sys_clk) pre_tick && pre_on);
  cov_irq_c:   cover property (@(posedge sys_clk) irq);

endmodule

// File: logic/pcu_params.svh
// constants for the port pin control unit
`ifndef PCU_PARAMS_SVH
`define PCU_PARAMS_SVH
// register offsets, chosen locally
`define PCU_OFF_PORTA_DATA  4'h0
`define PCU_OFF_PORTB_DATA  4'h1
`define PCU_OFF_PORTA_DIR   4'h2
`define PCU_OFF_PORTB_DIR   4'h3
`define PCU_OFF_RSVD_A      4'h4
`define PCU_OFF_PULL        4'h5
`define PCU_OFF_DRIVE       4'h6
`define PCU_OFF_CLKOUT      4'h7
`define PCU_OFF_RSVD_B      4'h8
`define PCU_OFF_IRQCFG      4'h9
`define PCU_OFF_IRQ_STATUS  4'ha
`define PCU_OFF_IRQ_CLEAR   4'hb
`define PCU_OFF_IRQ_ENABLE  4'hc
// field positions
`define PCU_BIT_DBG_PULLUP  6
`define PCU_BIT_B_PULLDN    1
`define PCU_BIT_A_PULLDN    0
`define PCU_BIT_B_WEAK      1
`define PCU_BIT_A_WEAK      0
`define PCU_BIT_CLK_DIS     7
`define PCU_BIT_PRE16       5
`define PCU_BIT_EDGE_SEL    7
`define PCU_BIT_MASK_CONN   6
`define PCU_BIT_NMI_CONN    5
// reset values and masks
`define PCU_RST_BYTE        8'h00
`define PCU_RST_CLKOUT      8'h00
`define PCU_RST_IRQCFG      8'h40
`define PCU_MASK_PULL       8'h43
`define PCU_MASK_DRIVE      8'h03
`define PCU_MASK_CLKOUT     8'ha0
`define PCU_MASK_IRQCFG     8'he0
`define PCU_MASK_IRQSTAT    8'h03
`define PCU_PRE16_LAST      4'hf
`define PCU_DIV_ZERO        5'h00
`endif

// File: logic/pcu_pkg.sv
// types for the port pin control unit
package pcu_pkg;
  typedef enum logic [2:0] {
    PCU_CLK_OFF   = 3'b001,
    PCU_CLK_RUN   = 3'b010,
    PCU_CLK_RSYNC = 3'b100
  } pcu_clk_state_t;
endpackage

// File: logic/pcu_sync8.sv
// two-stage input synchroniser for eight pins
`timescale 1ns/1ps
module pcu_sync8
  import pcu_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);
  logic [7:0] stage1;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      stage1   <= 8'h00;
      sync_out <= 8'h00;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// File: verif/pcu_pin_model.sv
// board-side model of the port pins and interrupt lines
`timescale 1ns/1ps
module pcu_pin_model (
  input  wire logic [7:0] port_a_out,
  input  wire logic [7:0] port_a_oe,
  input  wire logic [7:0] port_a_pulldown,
  input  wire logic [7:0] port_b_out,
  input  wire logic [7:0] port_b_oe,
  input  wire logic [7:0] port_b_pulldown,
  input  wire logic [7:0] ext_a,
  input  wire logic [7:0] ext_b,
  input  wire logic       mask_low,
  input  wire logic       nmi_low,
  output logic      [7:0] port_a_in,
  output logic      [7:0] port_a_in_unused,
  output logic      [7:0] port_b_in,
  output logic            maskable_pin,
  output logic            nonmaskable_interrupt_pin
);
  // outside sources are weak, so an enabled pull-down wins over them
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & ~port_a_pulldown & ext_a);
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & ~port_b_pulldown & ext_b);
  assign port_a_in_unused = ~port_a_in;
  // interrupt lines are pulled up and asserted low
  assign maskable_pin = ~mask_low;
  assign nonmaskable_interrupt_pin = ~nmi_low;
endmodule

// File: verif/test_port_pin_control_clkout_irq_cfg.sv
// self-checking bench for the port pin control unit
`timescale 1ns/1ps
`include "pcu_params.svh"
module test_port_pin_control_clkout_irq_cfg;
  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       special_mode = 1'b0;
  logic [7:0] seg_en_a = 8'h00;
  logic [7:0] seg_en_b = 8'h00;
  logic [7:0] ext_a = 8'h00;
  logic [7:0] ext_b = 8'h00;
  logic       dbg_out = 1'b0;
  logic       mask_low = 1'b0;
  logic       nmi_low = 1'b0;
  logic       svc_ack = 1'b0;
  wire logic [7:0] a_in, b_in, a_out, a_oe, a_ie, b_out, b_oe, b_ie, a_pd, b_pd, a_wk, b_wk;
  wire logic [7:0] reg_rdata;
  wire logic       dbg_pu, clk_out, mpin, npin, mreq, nreq, irq;
  int         mismatches = 0;
  int         checks = 0;
  logic [7:0] notes[$];
  logic       rd_seen = 1'b0;
  logic [31:0] rnd = 32'h0255;
  logic [7:0] d, s;
  logic [7:0] clk_cfgs [5] = '{8'h00, 8'h03, 8'h1f, 8'h20, 8'h21};
  logic       hi;

  always #2.5 sys_clk = ~sys_clk;

  pcu_top dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
    .seg_en_a(seg_en_a), .seg_en_b(seg_en_b), .port_a_in(a_in), .port_b_in(b_in),
    .port_a_out(a_out), .port_a_oe(a_oe), .port_a_ie(a_ie), .port_b_out(b_out),
    .port_b_oe(b_oe), .port_b_ie(b_ie), .port_a_pulldown(a_pd), .port_b_pulldown(b_pd),
    .port_a_weak(a_wk), .port_b_weak(b_wk), .debug_pin_is_output(dbg_out),
    .debug_pullup(dbg_pu), .bus_clock_out(clk_out), .maskable_pin(mpin),
    .nonmaskable_interrupt_pin(npin), .irq_service_ack(svc_ack), .maskable_irq_req(mreq),
    .nonmaskable_irq_req(nreq), .irq(irq));

  pcu_pin_model pins (.port_a_out(a_out), .port_a_oe(a_oe), .port_a_pulldown(a_pd),
    .port_b_out(b_out), .port_b_oe(b_oe), .port_b_pulldown(b_pd), .ext_a(ext_a),
    .ext_b(ext_b), .mask_low(mask_low), .nmi_low(nmi_low), .port_a_in(a_in),
    .port_a_in_unused(), .port_b_in(b_in), .maskable_pin(mpin),
    .nonmaskable_interrupt_pin(npin));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic complete_run;
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // expected read data waits in the queue until the monitor sees it
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    notes.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask

  task automatic clk_per(input logic [7:0] cfg);
    int t0, c;
    logic prev;
    wr(`PCU_OFF_CLKOUT, cfg);
    t0 = -1;
    c = 0;
    prev = 1'b1;
    while (c < 1200)
    begin
      @(posedge sys_clk);
      #1;
      c++;
      if (!prev && clk_out)
      begin
        if (t0 >= 0)
          break;
        t0 = c;
      end
      prev = clk_out;
    end
    chk(8'(c - t0), 8'(2 * (cfg[4:0] + 1) * (cfg[5] ? 16 : 1)));
  endtask

  //--------------------------------------------------------------
  // read data monitor
  //--------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (rd_seen)
      chk(reg_rdata, notes.pop_front());
    rd_seen <= reg_rd;
  end

  // bound well above the expected run of about 590 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    complete_run;
  end

  //--------------------------------------------------------------
  // main sequence
  //--------------------------------------------------------------
  initial
  begin
    do_reset;
    for (int i = 0; i < 16; i++)
      rd(4'(i), (i == 9) ? `PCU_RST_IRQCFG : 8'h00);
    wr(`PCU_OFF_RSVD_A, 8'hff);
    wr(`PCU_OFF_RSVD_B, 8'hff);
    rd(`PCU_OFF_RSVD_A, 8'h00);
    rd(`PCU_OFF_RSVD_B, 8'h00);
    wr(`PCU_OFF_PULL, 8'h43);
    rd(`PCU_OFF_PULL, 8'h03);
    wr(`PCU_OFF_DRIVE, 8'h03);
    rd(`PCU_OFF_DRIVE, 8'h03);
    repeat (8)
    begin
      rnd = lfsr(rnd);
      d = rnd[7:0];
      s = rnd[15:8];
      @(posedge sys_clk);
      seg_en_b <= s;
      seg_en_a <= ~s;
      wr(`PCU_OFF_PORTB_DIR, d);
      wr(`PCU_OFF_PORTA_DIR, ~d);
      settle;
      chk(b_oe, d & ~s);
      chk(b_ie, ~d & ~s);
      chk(a_oe, ~d & s);
      chk(b_pd, ~d & ~s);
      chk(a_pd, d & s);
      chk(b_wk, d);
      chk(a_wk, ~d);
      rd(`PCU_OFF_PORTB_DIR, d);
    end
    // debug pull-up only opens in special mode
    @(posedge sys_clk);
    special_mode <= 1'b1;
    seg_en_a <= 8'h00;
    seg_en_b <= 8'h00;
    ext_b <= 8'h3c;
    wr(`PCU_OFF_PULL, 8'h40);
    rd(`PCU_OFF_PULL, 8'h40);
    settle;
    chk({7'h0, dbg_pu}, 8'h01);
    dbg_out <= 1'b1;
    settle;
    chk({7'h0, dbg_pu}, 8'h00);
    special_mode <= 1'b0;
    wr(`PCU_OFF_PULL, 8'h00);
    rd(`PCU_OFF_PULL, 8'h40);
    // data source follows the direction bit
    wr(`PCU_OFF_PORTB_DIR, 8'hff);
    wr(`PCU_OFF_PORTB_DATA, 8'h5a);
    rd(`PCU_OFF_PORTB_DATA, 8'h5a);
    wr(`PCU_OFF_PORTB_DIR, 8'h00);
    // pin path needs the registered enable plus two sync flops to turn round
    settle;
    rd(`PCU_OFF_PORTB_DATA, 8'h3c);
    // clock output rates and disable
    foreach (clk_cfgs[i])
      clk_per(clk_cfgs[i]);
    wr(`PCU_OFF_CLKOUT, 8'h80);
    settle;
    hi = 1'b0;
    repeat (40)
    begin
      @(posedge sys_clk);
      hi = hi | clk_out;
    end
    chk({7'h0, hi}, 8'h00);
    // lock on edge select and nmi connect
    wr(`PCU_OFF_IRQCFG, 8'ha0);
    rd(`PCU_OFF_IRQCFG, 8'ha0);
    wr(`PCU_OFF_IRQCFG, 8'h40);
    rd(`PCU_OFF_IRQCFG, 8'he0);
    special_mode <= 1'b1;
    wr(`PCU_OFF_IRQCFG, 8'h40);
    rd(`PCU_OFF_IRQCFG, 8'h40);
    // level request, sticky status, clear
    wr(`PCU_OFF_IRQ_ENABLE, 8'h03);
    mask_low <= 1'b1;
    settle;
    chk({6'h0, irq, mreq}, 8'h03);
    mask_low <= 1'b0;
    settle;
    chk({7'h0, mreq}, 8'h00);
    rd(`PCU_OFF_IRQ_STATUS, 8'h01);
    wr(`PCU_OFF_IRQ_CLEAR, 8'h01);
    rd(`PCU_OFF_IRQ_STATUS, 8'h00);
    wr(`PCU_OFF_IRQCFG, 8'h00);
    mask_low <= 1'b1;
    settle;
    chk({6'h0, irq, mreq}, 8'h00);
    mask_low <= 1'b0;
    // falling edge latched until serviced
    wr(`PCU_OFF_IRQCFG, 8'he0);
    mask_low <= 1'b1;
    settle;
    mask_low <= 1'b0;
    settle;
    chk({7'h0, mreq}, 8'h01);
    svc_ack <= 1'b1;
    @(posedge sys_clk);
    svc_ack <= 1'b0;
    settle;
    chk({7'h0, mreq}, 8'h00);
    wr(`PCU_OFF_IRQ_CLEAR, 8'h03);
    nmi_low <= 1'b1;
    settle;
    chk({7'h0, nreq}, 8'h01);
    rd(`PCU_OFF_IRQ_STATUS, 8'h02);
    wr(`PCU_OFF_IRQ_ENABLE, 8'h01);
    settle;
    chk({7'h0, irq}, 8'h00);
    wr(`PCU_OFF_IRQCFG, 8'h40);
    settle;
    chk({7'h0, nreq}, 8'h00);
    nmi_low <= 1'b0;
    special_mode <= 1'b0;
    // a reset releases the lock
    do_reset;
    wr(`PCU_OFF_IRQCFG, 8'ha0);
    rd(`PCU_OFF_IRQCFG, 8'ha0);
    repeat (4) @(posedge sys_clk);
    complete_run;
  end
endmodule
